// ### logic/bas_seq.sv
// Batch activity sequencer with Avalon-MM register access.
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none

module bas_seq #(
  parameter int TICK_CYCLES = bas_pkg::TICK_CYCLES,
  parameter int WEIGHT_W    = 25
) (
  input  wire logic                bas_clk_unused_dummy_n,
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output var  logic [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     irq,
  input  wire logic [17:0]         ack_in,
  input  wire logic [WEIGHT_W-1:0] gross_weight,
  input  wire logic                stable_in,
  output var  logic                fine_out,
  output var  logic                dump_out
);

  localparam int IRQ_W_L = bas_pkg::IRQ_W;
  localparam bas_pkg::bas_state_e ST_IDLE_L = bas_pkg::ST_IDLE;

  logic                  ack_reg;
  logic                  wr_go;
  logic [31:0]           rd_mux;
  logic                  start_pulse;
  logic                  abort_pulse;
  logic                  dump_mode_reg;
  logic [2:0]            ack_mode_reg;
  logic [4:0]            ack_sel_reg;
  logic [13:0]           pulse_time_reg;
  logic [13:0]           batch_tmo_reg;
  logic [13:0]           dump_tmo_reg;
  logic [13:0]           settle_time_reg;
  logic [13:0]           dump_wait_reg;
  logic [WEIGHT_W-1:0]   setpoint_reg;
  logic [13:0]           tol_minus_reg;
  logic [13:0]           tol_plus_reg;
  logic [WEIGHT_W-1:0]   low_level_reg;
  logic [IRQ_W_L-1:0]    irq_status_reg;
  logic [IRQ_W_L-1:0]    irq_mask_reg;
  logic [IRQ_W_L-1:0]    irq_events;
  logic [31:0]           tick_cnt_reg;
  logic                  tick;
  logic [13:0]           phase_cnt_reg;
  logic [16:0]           tmo_cnt_reg;
  logic [16:0]           tmo_lim;
  logic [13:0]           tmo_sel;
  bas_pkg::bas_state_e   state_reg;
  bas_pkg::bas_state_e   state_d_reg;
  logic                  ack_level;
  logic                  cont_sup;
  logic                  ack_lost;
  logic                  active;
  logic                  tmo_hit;
  logic                  at_start_fail;
  logic signed [47:0]    w_x;
  logic signed [47:0]    lo_x;
  logic signed [47:0]    hi_x;
  logic signed [15:0]    lo_f;
  logic signed [15:0]    hi_f;
  logic                  minus_err;
  logic                  plus_err;
  logic                  pulse_nz;
  logic                  stable_done;
  logic                  phase_ok;

  function automatic logic [31:0] bas_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Bus slave: one wait cycle, then the request completes.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_go           = avs_write & ack_reg;
  assign start_pulse     = wr_go && avs_address == bas_pkg::OFF_CTRL
                           && avs_byteenable[0] && avs_writedata[bas_pkg::CTRL_START];
  assign abort_pulse     = wr_go && avs_address == bas_pkg::OFF_CTRL
                           && avs_byteenable[0] && avs_writedata[bas_pkg::CTRL_ABORT];

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (avs_address == bas_pkg::OFF_CTRL)
      rd_mux[bas_pkg::CTRL_DUMP] = dump_mode_reg;
    else if (avs_address == bas_pkg::OFF_STATUS)
      rd_mux[7:0] = {ack_level, dump_out, fine_out, active, 1'b0, state_reg};
    else if (avs_address == bas_pkg::OFF_ACK_CFG)
    begin
      rd_mux[2:0] = ack_mode_reg;
      if (ack_mode_reg != bas_pkg::ACK_NONE)
        rd_mux[bas_pkg::ACK_SEL_LSB +: bas_pkg::ACK_SEL_W] = ack_sel_reg;
    end
    else if (avs_address == bas_pkg::OFF_PULSE_TIME)
      rd_mux[13:0] = pulse_time_reg;
    else if (avs_address == bas_pkg::OFF_BATCH_TMO)
      rd_mux[13:0] = batch_tmo_reg;
    else if (avs_address == bas_pkg::OFF_DUMP_TMO)
      rd_mux[13:0] = dump_tmo_reg;
    else if (avs_address == bas_pkg::OFF_SETTLE_TIME)
      rd_mux[13:0] = settle_time_reg;
    else if (avs_address == bas_pkg::OFF_DUMP_WAIT)
      rd_mux[13:0] = dump_wait_reg;
    else if (avs_address == bas_pkg::OFF_SETPOINT)
      rd_mux = 32'($signed(setpoint_reg));
    else if (avs_address == bas_pkg::OFF_TOLERANCE)
    begin
      rd_mux[bas_pkg::TOL_MINUS_LSB +: 14] = tol_minus_reg;
      rd_mux[bas_pkg::TOL_PLUS_LSB +: 14]  = tol_plus_reg;
    end
    else if (avs_address == bas_pkg::OFF_LOW_LEVEL)
      rd_mux = 32'($signed(low_level_reg));
    else if (avs_address == bas_pkg::OFF_IRQ_STATUS)
      rd_mux[IRQ_W_L-1:0] = irq_status_reg;
    else if (avs_address == bas_pkg::OFF_IRQ_MASK)
      rd_mux[IRQ_W_L-1:0] = irq_mask_reg;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      avs_readdata <= 32'h00000000;
    else if (avs_read & ~ack_reg)
      avs_readdata <= rd_mux;
  end

  // Configuration registers written by software.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dump_mode_reg   <= 1'b0;
      ack_mode_reg    <= bas_pkg::ACK_NONE;
      ack_sel_reg     <= bas_pkg::RST_ACK_SEL;
      pulse_time_reg  <= bas_pkg::RST_PULSE_TIME;
      batch_tmo_reg   <= bas_pkg::RST_TMO;
      dump_tmo_reg    <= bas_pkg::RST_TMO;
      settle_time_reg <= bas_pkg::RST_SETTLE_TIME;
      dump_wait_reg   <= bas_pkg::RST_DUMP_WAIT;
      setpoint_reg    <= '0;
      tol_minus_reg   <= bas_pkg::TOL_FULL;
      tol_plus_reg    <= bas_pkg::TOL_FULL;
      low_level_reg   <= '0;
      irq_mask_reg    <= '0;
    end
    else if (wr_go)
    begin
      if (avs_address == bas_pkg::OFF_CTRL && avs_byteenable[0] && state_reg == ST_IDLE_L)
        dump_mode_reg <= avs_writedata[bas_pkg::CTRL_DUMP];
      else if (avs_address == bas_pkg::OFF_ACK_CFG)
      begin
        if (avs_byteenable[0])
          ack_mode_reg <= avs_writedata[2:0];
        if (avs_byteenable[1])
          ack_sel_reg <= avs_writedata[bas_pkg::ACK_SEL_LSB +: bas_pkg::ACK_SEL_W];
      end
      else if (avs_address == bas_pkg::OFF_PULSE_TIME)
        pulse_time_reg <= 14'(bas_merge(32'(pulse_time_reg), avs_writedata, avs_byteenable));
      else if (avs_address == bas_pkg::OFF_BATCH_TMO)
        batch_tmo_reg <= 14'(bas_merge(32'(batch_tmo_reg), avs_writedata, avs_byteenable));
      else if (avs_address == bas_pkg::OFF_DUMP_TMO)
        dump_tmo_reg <= 14'(bas_merge(32'(dump_tmo_reg), avs_writedata, avs_byteenable));
      else if (avs_address == bas_pkg::OFF_SETTLE_TIME)
        settle_time_reg <= 14'(bas_merge(32'(settle_time_reg), avs_writedata, avs_byteenable));
      else if (avs_address == bas_pkg::OFF_DUMP_WAIT)
        dump_wait_reg <= 14'(bas_merge(32'(dump_wait_reg), avs_writedata, avs_byteenable));
      else if (avs_address == bas_pkg::OFF_SETPOINT)
        setpoint_reg <= WEIGHT_W'(bas_merge(32'(setpoint_reg), avs_writedata,
                                            avs_byteenable));
      else if (avs_address == bas_pkg::OFF_TOLERANCE)
      begin
        tol_minus_reg <= 14'(bas_merge(32'(tol_minus_reg), avs_writedata, avs_byteenable));
        tol_plus_reg  <= 14'(bas_merge({2'b00, tol_plus_reg, 16'h0000}, avs_writedata,
                                       avs_byteenable) >> 16);
      end
      else if (avs_address == bas_pkg::OFF_LOW_LEVEL)
        low_level_reg <= WEIGHT_W'(bas_merge(32'(low_level_reg), avs_writedata,
                                             avs_byteenable));
      else if (avs_address == bas_pkg::OFF_IRQ_MASK)
        irq_mask_reg <= IRQ_W_L'(bas_merge(32'(irq_mask_reg), avs_writedata,
                                           avs_byteenable));
    end
  end

  // Acknowledge input selection and supervision.
  assign ack_level = (ack_sel_reg < 5'(bas_pkg::ACK_INPUTS)) ? ack_in[ack_sel_reg] : 1'b0;
  assign cont_sup  = ack_mode_reg == bas_pkg::ACK_CONT
                     || ack_mode_reg == bas_pkg::ACK_WAIT_CONT;
  assign active    = state_reg != bas_pkg::ST_IDLE && state_reg != bas_pkg::ST_ACK_WAIT;
  assign ack_lost  = cont_sup & active & ~ack_level;
  assign at_start_fail = start_pulse && state_reg == bas_pkg::ST_IDLE
                         && ack_mode_reg == bas_pkg::ACK_AT_START && !ack_level;

  // Tenth-of-a-second time base.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      tick_cnt_reg <= 32'h00000000;
    else if (tick)
      tick_cnt_reg <= 32'h00000000;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
  end

  assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);

  // Phase timer restarts whenever the state changes; its count is stale for one cycle.
  assign phase_ok = state_reg == state_d_reg;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_d_reg   <= bas_pkg::ST_IDLE;
      phase_cnt_reg <= 14'h0000;
    end
    else
    begin
      state_d_reg <= state_reg;
      if (state_reg != state_d_reg)
        phase_cnt_reg <= 14'h0000;
      else if (tick && phase_cnt_reg != 14'h3FFF)
        phase_cnt_reg <= phase_cnt_reg + 14'h0001;
    end
  end

  // Activity timeout counted in tenths from the start of the activity.
  assign tmo_sel = dump_mode_reg ? dump_tmo_reg : batch_tmo_reg;
  assign tmo_lim = 17'(tmo_sel) * 17'(bas_pkg::TENTHS_PER_S);
  assign tmo_hit = active && tmo_sel != 14'h0000 && tmo_cnt_reg >= tmo_lim;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      tmo_cnt_reg <= 17'h00000;
    else if (!active)
      tmo_cnt_reg <= 17'h00000;
    else if (tick && tmo_cnt_reg != 17'h1FFFF)
      tmo_cnt_reg <= tmo_cnt_reg + 17'h00001;
  end

  // Tolerance checks scaled to hundredths of a percent.
  assign lo_f      = $signed(16'(bas_pkg::TOL_FULL) - 16'(tol_minus_reg));
  assign hi_f      = $signed(16'(bas_pkg::TOL_FULL) + 16'(tol_plus_reg));
  assign w_x       = 48'($signed(gross_weight)) * 48'(bas_pkg::TOL_FULL);
  assign lo_x      = 48'($signed(setpoint_reg)) * 48'(lo_f);
  assign hi_x      = 48'($signed(setpoint_reg)) * 48'(hi_f);
  assign minus_err = tol_minus_reg < bas_pkg::TOL_FULL && w_x < lo_x;
  assign plus_err  = tol_plus_reg < bas_pkg::TOL_FULL && w_x > hi_x;
  assign pulse_nz  = pulse_time_reg != 14'h0000;
  assign stable_done = state_reg == bas_pkg::ST_STABLE && stable_in;

  // Activity sequence.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= bas_pkg::ST_IDLE;
    else if (abort_pulse || tmo_hit)
      state_reg <= bas_pkg::ST_IDLE;
    else
    begin
      case (state_reg)
        bas_pkg::ST_IDLE:
          if (start_pulse)
          begin
            if (ack_mode_reg == bas_pkg::ACK_WAIT || ack_mode_reg == bas_pkg::ACK_WAIT_CONT)
              state_reg <= bas_pkg::ST_ACK_WAIT;
            else if (!at_start_fail)
              state_reg <= bas_pkg::ST_RUN;
          end
        bas_pkg::ST_ACK_WAIT:
          if (ack_level)
            state_reg <= bas_pkg::ST_RUN;
        bas_pkg::ST_RUN:
          if (dump_mode_reg && $signed(gross_weight) <= $signed(low_level_reg))
            state_reg <= bas_pkg::ST_DUMP_HOLD;
          else if (!dump_mode_reg && $signed(gross_weight) >= $signed(setpoint_reg))
            state_reg <= bas_pkg::ST_SETTLE;
        bas_pkg::ST_DUMP_HOLD:
          if (phase_ok && phase_cnt_reg >= dump_wait_reg)
            state_reg <= bas_pkg::ST_IDLE;
        bas_pkg::ST_SETTLE:
          if (phase_ok && phase_cnt_reg >= settle_time_reg)
            state_reg <= bas_pkg::ST_STABLE;
        bas_pkg::ST_STABLE:
          if (stable_in)
            state_reg <= (minus_err && pulse_nz) ? bas_pkg::ST_PULSE : bas_pkg::ST_IDLE;
        bas_pkg::ST_PULSE:
          if (phase_ok && phase_cnt_reg >= pulse_time_reg)
            state_reg <= bas_pkg::ST_SETTLE;
        default:
          state_reg <= bas_pkg::ST_IDLE;
      endcase
    end
  end

  // Plant outputs, held off while acknowledge is lost.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fine_out <= 1'b0;
      dump_out <= 1'b0;
    end
    else
    begin
      fine_out <= !dump_mode_reg && !ack_lost && !abort_pulse && !tmo_hit
                  && (state_reg == bas_pkg::ST_RUN || state_reg == bas_pkg::ST_PULSE);
      dump_out <= dump_mode_reg && !ack_lost && !abort_pulse && !tmo_hit
                  && (state_reg == bas_pkg::ST_RUN
                      || (state_reg == bas_pkg::ST_DUMP_HOLD
                          && (!phase_ok || phase_cnt_reg < dump_wait_reg)));
    end
  end

  // Sticky event flags; a new event wins over a write-one clear.
  always_comb
  begin
    irq_events = '0;
    irq_events[bas_pkg::IRQ_DONE]  = !tmo_hit && !abort_pulse
                                     && ((state_reg == bas_pkg::ST_DUMP_HOLD
                                          && phase_ok && phase_cnt_reg >= dump_wait_reg)
                                         || (stable_done && !(minus_err && pulse_nz)));
    irq_events[bas_pkg::IRQ_TMO]   = tmo_hit;
    irq_events[bas_pkg::IRQ_ACK]   = ack_lost || at_start_fail;
    irq_events[bas_pkg::IRQ_MINUS] = stable_done && minus_err;
    irq_events[bas_pkg::IRQ_PLUS]  = stable_done && plus_err;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_status_reg <= '0;
    else if (wr_go && avs_address == bas_pkg::OFF_IRQ_STATUS && avs_byteenable[0])
      irq_status_reg <= (irq_status_reg & ~avs_writedata[IRQ_W_L-1:0]) | irq_events;
    else
      irq_status_reg <= irq_status_reg | irq_events;
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

endmodule // bas_seq

`default_nettype wire

// ### logic/bas_pkg.sv
// Constants shared by the batch activity sequencer.
package bas_pkg;

  // Register byte offsets.
  localparam logic [5:0] OFF_CTRL        = 6'h00;
  localparam logic [5:0] OFF_STATUS      = 6'h04;
  localparam logic [5:0] OFF_ACK_CFG     = 6'h08;
  localparam logic [5:0] OFF_PULSE_TIME  = 6'h0C;
  localparam logic [5:0] OFF_BATCH_TMO   = 6'h10;
  localparam logic [5:0] OFF_DUMP_TMO    = 6'h14;
  localparam logic [5:0] OFF_SETTLE_TIME = 6'h18;
  localparam logic [5:0] OFF_DUMP_WAIT   = 6'h1C;
  localparam logic [5:0] OFF_SETPOINT    = 6'h20;
  localparam logic [5:0] OFF_TOLERANCE   = 6'h24;
  localparam logic [5:0] OFF_LOW_LEVEL   = 6'h28;
  localparam logic [5:0] OFF_IRQ_STATUS  = 6'h2C;
  localparam logic [5:0] OFF_IRQ_MASK    = 6'h30;

  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;
  localparam int CTRL_DUMP  = 2;

  // Acknowledge configuration fields.
  localparam int ACK_MODE_LSB = 0;
  localparam int ACK_SEL_LSB  = 8;
  localparam int ACK_SEL_W    = 5;
  localparam int ACK_INPUTS   = 18;

  // Tolerance register fields, in hundredths of a percent.
  localparam int TOL_MINUS_LSB = 0;
  localparam int TOL_PLUS_LSB  = 16;
  localparam logic [13:0] TOL_FULL = 14'h2710;

  // Interrupt status bit positions.
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_TMO   = 1;
  localparam int IRQ_ACK   = 2;
  localparam int IRQ_MINUS = 3;
  localparam int IRQ_PLUS  = 4;
  localparam int IRQ_W     = 5;

  // Reset values; times in tenths of a second, timeouts in seconds.
  localparam logic [13:0] RST_PULSE_TIME  = 14'h0000;
  localparam logic [13:0] RST_TMO         = 14'h0000;
  localparam logic [13:0] RST_SETTLE_TIME = 14'h0032;
  localparam logic [13:0] RST_DUMP_WAIT   = 14'h0032;
  localparam logic [4:0]  RST_ACK_SEL     = 5'h00;

  // Time base: one tick each tenth of a second.
  localparam int TENTH_NS     = 32'h05F5E100;
  localparam int CLK_NS       = 32'h00000064;
  localparam int TICK_CYCLES  = TENTH_NS / CLK_NS;
  localparam int TENTHS_PER_S = 32'h0000000A;

  typedef enum logic [2:0] {
    ACK_NONE,
    ACK_AT_START,
    ACK_WAIT,
    ACK_CONT,
    ACK_WAIT_CONT
  } bas_ack_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACK_WAIT,
    ST_RUN,
    ST_DUMP_HOLD,
    ST_SETTLE,
    ST_STABLE,
    ST_PULSE
  } bas_state_e;

endpackage

// ### tb/bas_seq_checker.sv
// Port assertions for the batch activity sequencer.
`timescale 1ns/1ps
`default_nettype none
module bas_seq_checker #(
  parameter int TICK_CYCLES = 10,
  parameter int WEIGHT_W    = 25
) (
  input wire logic                clk_sys,
  input wire logic                rst_b,
  input wire logic [5:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_writedata,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire logic                irq,
  input wire logic [WEIGHT_W-1:0] gross_weight,
  input wire logic                fine_out,
  input wire logic                dump_out
);
  logic signed [WEIGHT_W-1:0] low_reg;
  logic                       wr_seen_reg;
  wire                        acc_wr = avs_write && !avs_waitrequest;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      low_reg <= '0;
    else if (acc_wr && avs_address == bas_pkg::OFF_LOW_LEVEL)
      low_reg <= avs_writedata[WEIGHT_W-1:0];
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      wr_seen_reg <= 1'b0;
    else if (acc_wr)
      wr_seen_reg <= 1'b1;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  sequence req_pending;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence low_reached;
    dump_out && ($signed(gross_weight) <= low_reg);
  endsequence
  wait_one_a: assert property (req_pending |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  no_req_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
  reset_quiet_a: assert property ($rose(rst_b) |-> !fine_out && !dump_out && !irq)
    else $error("outputs active after reset");
  out_excl_a: assert property (!(fine_out && dump_out))
    else $error("fine and dump outputs both on");
  irq_fall_a: assert property ($fell(irq) |-> $past(acc_wr))
    else $error("interrupt dropped without a write");
  irq_quiet_a: assert property (!wr_seen_reg |-> !irq)
    else $error("interrupt before any write");
  dump_end_a: assert property (low_reached |-> ##[1:600] !dump_out)
    else $error("dump output stayed on after wait time");
endmodule // bas_seq_checker
bind bas_seq bas_seq_checker #(.TICK_CYCLES(TICK_CYCLES), .WEIGHT_W(WEIGHT_W)) i_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .gross_weight(gross_weight),
  .fine_out(fine_out), .dump_out(dump_out));
`default_nettype wire

// ### tb/bas_plant.sv
// Plant model: scale weight, stability and acknowledge contacts.
`timescale 1ns/1ps
`default_nettype none
module bas_plant (
  input  wire logic        clk_sys,
  input  wire logic        fine_out,
  input  wire logic        dump_out,
  input  wire logic        ld,
  input  wire logic [24:0] ld_val,
  input  wire logic        ack_on,
  input  wire logic [4:0]  ack_sel,
  output var  logic [17:0] ack_in,
  output var  logic [24:0] gross_weight,
  output var  logic        stable_in
);
  logic [17:0] noise = 18'h2A5A5;
  always_ff @(posedge clk_sys)
  begin
    noise <= {noise[16:0], noise[17] ^ noise[10]};
    ack_in <= (noise & ~(18'h00001 << ack_sel)) | (18'(ack_on) << ack_sel);
    gross_weight <= ld ? ld_val : gross_weight + 25'(fine_out) - 25'(dump_out);
    stable_in <= !(fine_out || dump_out);
  end
endmodule // bas_plant
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the batch activity sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        ld = 1'b1, ack_on = 1'b0, avs_waitrequest, irq, fine_out, dump_out, stable_in;
  logic [5:0]  avs_address = 6'h00;
  logic [4:0]  sel = 5'h00;
  logic [17:0] ack_in;
  logic [24:0] ld_val = 25'h0000000, gross_weight;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata, r, sp, lo;
  int          seed, fail_count = 0, checks = 0, n;
  logic [5:0]  ra [8] = '{bas_pkg::OFF_PULSE_TIME, bas_pkg::OFF_BATCH_TMO, bas_pkg::OFF_DUMP_TMO,
    bas_pkg::OFF_SETTLE_TIME, bas_pkg::OFF_DUMP_WAIT, bas_pkg::OFF_ACK_CFG,
    bas_pkg::OFF_TOLERANCE, 6'h3C};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h32, 32'h32, 32'h0, 32'h27102710, 32'h0};
  bas_seq #(.TICK_CYCLES(10)) i_dut (.bas_clk_unused_dummy_n(1'b1), .clk_sys(clk_sys),
    .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .ack_in(ack_in),
    .gross_weight(gross_weight), .stable_in(stable_in), .fine_out(fine_out),
    .dump_out(dump_out));
  bas_plant i_plant (.clk_sys(clk_sys), .fine_out(fine_out), .dump_out(dump_out), .ld(ld),
    .ld_val(ld_val), .ack_on(ack_on), .ack_sel(sel), .ack_in(ack_in),
    .gross_weight(gross_weight), .stable_in(stable_in));
  initial forever #50 clk_sys = ~clk_sys;
  function automatic logic [31:0] exp_ack(input int m, input logic [4:0] s);
    return m == 0 ? 32'h0 : {19'h0, s, 5'h0, 3'(m)};
  endfunction
  function automatic int cyc(input int t);
    return t * 10;
  endfunction
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(negedge clk_sys);
    while (avs_waitrequest !== 1'b0 && k < 50)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 50)
      fail_count++;
    @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_out(input logic dmp, input logic v, input int lim, output int c);
    c = 0;
    while ((dmp ? dump_out : fine_out) !== v && c < lim)
    begin
      @(negedge clk_sys);
      c++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10000) @(posedge clk_sys);
    fail_count++;
    finish_test();
  end
  initial
  begin
    seed = 32'h7252;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    sel <= 5'($unsigned($random(seed)) % 18);
    wr(6'h3C, 32'hFFFFFFFF);
    foreach (ra[i])
    begin
      rd(ra[i], r);
      chk(r, rv[i]);
    end
    $display("test reset values done");
    wr(bas_pkg::OFF_ACK_CFG, {19'h0, sel, 8'h00});
    rd(bas_pkg::OFF_ACK_CFG, r);
    chk(r, exp_ack(0, sel));
    wr(bas_pkg::OFF_ACK_CFG, exp_ack(1, sel));
    rd(bas_pkg::OFF_ACK_CFG, r);
    chk(r, exp_ack(1, sel));
    wr(bas_pkg::OFF_SETPOINT, 32'h00100000);
    wr(bas_pkg::OFF_CTRL, 32'h1);
    rd(bas_pkg::OFF_STATUS, r);
    chk(32'(r[2:0]), 32'h0);
    rd(bas_pkg::OFF_IRQ_STATUS, r);
    chk(32'(r[bas_pkg::IRQ_ACK]), 32'h1);
    chk(32'(irq), 32'h0);
    wr(bas_pkg::OFF_IRQ_MASK, 32'h4);
    @(negedge clk_sys);
    chk(32'(irq), 32'h1);
    wr(bas_pkg::OFF_IRQ_STATUS, 32'h4);
    @(negedge clk_sys);
    chk(32'(irq), 32'h0);
    ack_on <= 1'b1;
    wr(bas_pkg::OFF_CTRL, 32'h1);
    wait_out(1'b0, 1'b1, 5, n);
    chk(32'(fine_out), 32'h1);
    wr(bas_pkg::OFF_CTRL, 32'h2);
    for (int m = 2; m <= 4; m++)
    begin
      ack_on <= 1'b0;
      wr(bas_pkg::OFF_ACK_CFG, exp_ack(m, sel));
      wr(bas_pkg::OFF_IRQ_STATUS, 32'h1F);
      wr(bas_pkg::OFF_CTRL, 32'h1);
      repeat (4) @(negedge clk_sys);
      chk(32'(fine_out), 32'h0);
      ack_on <= 1'b1;
      wait_out(1'b0, 1'b1, 5, n);
      chk(32'(fine_out), 32'h1);
      ack_on <= 1'b0;
      repeat (4) @(negedge clk_sys);
      chk(32'(fine_out), 32'(m == 2));
      rd(bas_pkg::OFF_IRQ_STATUS, r);
      chk(32'(r[bas_pkg::IRQ_ACK]), 32'(m != 2));
      wr(bas_pkg::OFF_CTRL, 32'h2);
    end
    $display("test acknowledge modes done");
    wr(bas_pkg::OFF_ACK_CFG, 32'h0);
    wr(bas_pkg::OFF_BATCH_TMO, 32'h1);
    wr(bas_pkg::OFF_IRQ_STATUS, 32'h1F);
    wr(bas_pkg::OFF_CTRL, 32'h1);
    wait_out(1'b0, 1'b1, 5, n);
    wait_out(1'b0, 1'b0, 200, n);
    chk(32'(n >= cyc(10) - 15 && n <= cyc(10) + 5), 32'h1);
    rd(bas_pkg::OFF_IRQ_STATUS, r);
    chk(32'(r[bas_pkg::IRQ_TMO]), 32'h1);
    wr(bas_pkg::OFF_BATCH_TMO, 32'h0);
    wr(bas_pkg::OFF_SETTLE_TIME, 32'h2);
    for (int i = 0; i < 3; i++)
    begin
      sp = 32'(($unsigned($random(seed)) % 4000) + 1000);
      ld_val <= 25'h0;
      wr(bas_pkg::OFF_SETPOINT, sp);
      wr(bas_pkg::OFF_TOLERANCE, i == 1 ? 32'h27102710 : 32'h27100064);
      wr(bas_pkg::OFF_PULSE_TIME, i == 2 ? 32'h0 : 32'h3);
      wr(bas_pkg::OFF_IRQ_STATUS, 32'h1F);
      wr(bas_pkg::OFF_CTRL, 32'h1);
      wait_out(1'b0, 1'b1, 5, n);
      ld_val <= 25'(sp);
      wait_out(1'b0, 1'b0, 5, n);
      ld_val <= 25'(sp - sp / 10);
      wait_out(1'b0, 1'b1, 60, n);
      chk(32'(n < 60 && n >= cyc(2) - 10), 32'(i == 0));
      wait_out(1'b0, 1'b0, 40, n);
      chk(32'(n >= cyc(3) - 10 && n <= cyc(3) + 2), 32'(i == 0));
      ld_val <= 25'(sp);
      repeat (60) @(posedge clk_sys);
      rd(bas_pkg::OFF_IRQ_STATUS, r);
      chk(32'(r[bas_pkg::IRQ_DONE]), 32'h1);
      chk(32'(r[bas_pkg::IRQ_MINUS]), 32'(i != 1));
    end
    $display("test pulsing done");
    lo = 32'($random(seed) % 1000);
    wr(bas_pkg::OFF_LOW_LEVEL, lo);
    wr(bas_pkg::OFF_CTRL, 32'h4);
    for (int k = 0; k < 2; k++)
    begin
      wr(bas_pkg::OFF_DUMP_TMO, 32'(k));
      wr(bas_pkg::OFF_IRQ_STATUS, 32'h1F);
      ld_val <= 25'(lo + (k == 0 ? 20 : 5000));
      @(posedge clk_sys);
      ld <= 1'b0;
      wr(bas_pkg::OFF_CTRL, 32'h5);
      wait_out(1'b1, 1'b1, 5, n);
      wait_out(1'b1, 1'b0, 700, n);
      chk(32'(k == 0 ? n >= cyc(50) + 5 && n <= cyc(50) + 30
                     : n >= cyc(10) - 15 && n <= cyc(10) + 5), 32'h1);
      rd(bas_pkg::OFF_IRQ_STATUS, r);
      chk(32'(r[k]), 32'h1);
      ld <= 1'b1;
    end
    $display("test dumping done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
